/* File: hw/tbj_pkg.sv */
// Constants, types and register map of the 10Base-T supervision block.
// Assumes a 20 MHz hclk; every 10Base-T interval derives from it.
`default_nettype none
package tbj_pkg;
    // Clock and bit timing
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_NS = 50;
    localparam int BIT_NS = 100;
    localparam int BIT_CYC = BIT_NS / CLK_NS;
    // Long intervals in milliseconds
    localparam int JAB_MS = 20;
    localparam int UNJAB_MS = 500;
    localparam int LINK_FAIL_MS = 83;
    localparam int NLP_MS = 16;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int JAB_CYC = JAB_MS * CYC_PER_MS;
    localparam int UNJAB_CYC = UNJAB_MS * CYC_PER_MS;
    localparam int LINK_FAIL_CYC = LINK_FAIL_MS * CYC_PER_MS;
    localparam int NLP_CYC = NLP_MS * CYC_PER_MS;
    localparam int CNT_W = 24;
    // Heartbeat timing in bit times
    localparam logic [3:0] SQE_DLY_BT = 4'h8;
    localparam logic [3:0] SQE_LEN_BT = 4'hA;
    localparam int SQE_ON_CYC = int'(SQE_LEN_BT) * BIT_CYC;
    // Link and polarity thresholds
    localparam logic [3:0] LINK_NLP_MIN = 4'h8;
    localparam logic [1:0] POL_REV_MIN = 2'h2;
    // Register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK = 4'hC;
    // Field positions
    localparam int CTRL_SQE_INH = 2;
    localparam int CTRL_POL_INH = 3;
    localparam int CTRL_JAB_INH = 5;
    localparam int STAT_LINK = 0;
    localparam int STAT_JAB = 2;
    localparam int STAT_POL = 14;
    localparam int IRQ_JAB = 0;
    localparam int IRQ_POL = 1;
    localparam int IRQ_LFAIL = 2;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [2:0] IRQ_RST = 3'h0;
    // Jabber and heartbeat states, Gray along the path
    typedef enum logic [1:0] {
        JAB_IDLE = 2'b00,
        JAB_TX = 2'b01,
        JAB_CUT = 2'b11
    } tbj_jab_t;
    typedef enum logic [1:0] {
        SQE_IDLE = 2'b00,
        SQE_WAIT = 2'b01,
        SQE_ON = 2'b11
    } tbj_sqe_t;
    // MII side inputs and line side outputs
    typedef struct packed {
        logic tx_en;
        logic tx_data;
        logic rx_active;
    } tbj_mii_t;
    typedef struct packed {
        logic tx_drive;
        logic tx_data;
        logic nlp_send;
        logic rx_data;
    } tbj_line_t;
endpackage
`default_nettype wire

/* File: hw/tbj_supervisor.sv */
// 10Base-T collision, jabber, heartbeat, link and polarity supervision.
// Assumes a single AHB-Lite master and MII/line inputs synchronous to hclk.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`default_nettype none
module tbj_supervisor #(
    parameter int JAB_CYCLES = tbj_pkg::JAB_CYC,
    parameter int UNJAB_CYCLES = tbj_pkg::UNJAB_CYC,
    parameter int LINK_FAIL_CYCLES = tbj_pkg::LINK_FAIL_CYC,
    parameter int NLP_CYCLES = tbj_pkg::NLP_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire tbj_pkg::tbj_mii_t mii,
    input wire logic full_duplex,
    input wire logic repeater_mode,
    input wire logic mode_100,
    input wire logic autoneg_active,
    input wire logic rx_data_raw,
    input wire logic nlp_seen_pos,
    input wire logic nlp_seen_neg,
    output logic col,
    output tbj_pkg::tbj_line_t line,
    output logic irq
);
    import tbj_pkg::*;

    logic [31:0] ctrl;
    logic [2:0] irq_stat, irq_mask;
    logic jab_lh, pol_lh, link_valid, pol_rev;
    logic bit_tick, tx_en_d;
    logic [$clog2(BIT_CYC)-1:0] bit_cnt;
    tbj_jab_t jab_st;
    tbj_sqe_t sqe_st;
    logic [CNT_W-1:0] jab_cnt, lf_cnt, nlp_cnt;
    logic [3:0] sqe_cnt, nlp_seen;
    logic [1:0] rev_cnt;
    logic [4:0] sqe_on_cyc;
    logic ap_valid, ap_write;
    logic [3:0] ap_ofs;
    logic stat_rd, jab_evt, pol_evt, lf_evt, sqe_ok, pol_window;
    logic jab_on, cut;
    // Register field decode, used in the address phase for both reads and writes
    function automatic logic [3:0] reg_ofs(input logic [31:0] a);
        return a[3:0];
    endfunction
    function automatic logic is_mapped(input logic [31:0] a);
        return a[31:4] == 28'h000_0000 && a[1:0] == 2'b00;
    endfunction

    assign jab_on = !ctrl[CTRL_JAB_INH];
    assign cut = jab_st == JAB_CUT;
    // Bit-time enable: one pulse every BIT_NS of clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_cnt <= '0;
        end else if (bit_cnt == ($bits(bit_cnt))'(BIT_CYC - 1)) begin
            bit_cnt <= '0;
        end else begin
            bit_cnt <= bit_cnt + 1'b1;
        end
    end
    assign bit_tick = bit_cnt == ($bits(bit_cnt))'(BIT_CYC - 1);
    // Bus address phase; zero wait states keep the master simple
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_ofs <= '0;
        end else if (hready) begin
            ap_valid <= hsel && htrans[1] && is_mapped(haddr);
            ap_write <= hwrite;
            ap_ofs <= reg_ofs(haddr);
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign stat_rd = hready && hsel && htrans[1] && !hwrite &&
        is_mapped(haddr) && reg_ofs(haddr) == OFS_STAT;
    // Read data registered in the address phase; unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready) begin
            hrdata <= 32'h0000_0000;
            if (hsel && htrans[1] && !hwrite && is_mapped(haddr)) begin
                case (reg_ofs(haddr))
                    OFS_CTRL: hrdata <= ctrl;
                    OFS_STAT: begin
                        hrdata[STAT_LINK] <= link_valid;
                        hrdata[STAT_JAB] <= jab_lh;
                        hrdata[STAT_POL] <= pol_lh;
                    end
                    OFS_IRQ_STAT: hrdata[2:0] <= irq_stat;
                    OFS_IRQ_MASK: hrdata[2:0] <= irq_mask;
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end
    // Control and mask writes, taken in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= CTRL_RST;
            irq_mask <= IRQ_RST;
        end else if (ap_valid && ap_write) begin
            if (ap_ofs == OFS_CTRL) begin
                ctrl <= hwdata & 32'h0000_002C;
            end
            if (ap_ofs == OFS_IRQ_MASK) begin
                irq_mask <= hwdata[2:0];
            end
        end
    end
    // Sticky interrupt bits; a new event beats a write-one clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= IRQ_RST;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (ap_valid && ap_write && ap_ofs == OFS_IRQ_STAT &&
                    hwdata[i]) begin
                    irq_stat[i] <= 1'b0;
                end
            end
            if (jab_evt) irq_stat[IRQ_JAB] <= 1'b1;
            if (pol_evt) irq_stat[IRQ_POL] <= 1'b1;
            if (lf_evt) irq_stat[IRQ_LFAIL] <= 1'b1;
        end
    end
    assign irq = |(irq_stat & irq_mask);
    // Jabber watch: run time while transmitting, then hold off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            jab_st <= JAB_IDLE;
            jab_cnt <= '0;
        end else begin
            case (jab_st)
                JAB_IDLE: begin
                    jab_cnt <= '0;
                    if (mii.tx_en && jab_on) jab_st <= JAB_TX;
                end
                JAB_TX: begin
                    jab_cnt <= jab_cnt + 1'b1;
                    if (!mii.tx_en || !jab_on) begin
                        jab_st <= JAB_IDLE;
                    end else if (jab_cnt == CNT_W'(JAB_CYCLES - 1)) begin
                        jab_st <= JAB_CUT;
                        jab_cnt <= '0;
                    end
                end
                JAB_CUT: begin
                    jab_cnt <= jab_cnt + 1'b1;
                    if (jab_cnt == CNT_W'(UNJAB_CYCLES - 1)) begin
                        jab_st <= JAB_IDLE;
                    end
                end
                default: jab_st <= JAB_IDLE;
            endcase
        end
    end
    assign jab_evt = jab_st == JAB_TX && mii.tx_en && jab_on &&
        jab_cnt == CNT_W'(JAB_CYCLES - 1);
    // Latched status: event wins, read lets it track the live state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            jab_lh <= 1'b0;
            pol_lh <= 1'b0;
        end else begin
            if (jab_evt) jab_lh <= 1'b1;
            else if (stat_rd) jab_lh <= cut;
            if (pol_evt) pol_lh <= 1'b1;
            else if (stat_rd) pol_lh <= pol_rev;
        end
    end
    // Heartbeat permission: node, half duplex, link up, not inhibited
    assign sqe_ok = !repeater_mode && !full_duplex && link_valid &&
        !ctrl[CTRL_SQE_INH];
    // Heartbeat sequencer: delay then a pulse, counted in bit times
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_en_d <= 1'b0;
            sqe_st <= SQE_IDLE;
            sqe_cnt <= '0;
        end else begin
            tx_en_d <= mii.tx_en;
            case (sqe_st)
                SQE_IDLE: begin
                    sqe_cnt <= '0;
                    if (tx_en_d && !mii.tx_en && sqe_ok) begin
                        sqe_st <= SQE_WAIT;
                    end
                end
                SQE_WAIT: begin
                    if (!sqe_ok) begin
                        sqe_st <= SQE_IDLE;
                    end else if (bit_tick) begin
                        sqe_cnt <= sqe_cnt + 1'b1;
                        if (sqe_cnt == SQE_DLY_BT - 1'b1) begin
                            sqe_st <= SQE_ON;
                            sqe_cnt <= '0;
                        end
                    end
                end
                SQE_ON: begin
                    if (!sqe_ok) begin
                        sqe_st <= SQE_IDLE;
                    end else if (bit_tick) begin
                        sqe_cnt <= sqe_cnt + 1'b1;
                        if (sqe_cnt == SQE_LEN_BT - 1'b1) begin
                            sqe_st <= SQE_IDLE;
                        end
                    end
                end
                default: sqe_st <= SQE_IDLE;
            endcase
        end
    end
    // Heartbeat on-time in cycles, so checks need no long repetition
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) sqe_on_cyc <= 5'h00;
        else sqe_on_cyc <= (sqe_st == SQE_ON) ? sqe_on_cyc + 5'h01 : 5'h00;
    end
    // Collision output; full duplex forces it low over every source
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            col <= 1'b0;
        end else if (full_duplex) begin
            col <= 1'b0;
        end else begin
            col <= (mii.tx_en && mii.rx_active && !cut) ||
                cut ||
                sqe_st == SQE_ON;
        end
    end
    // Link monitor: pulse count to come up, silence timer to fail
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_valid <= 1'b0;
            lf_cnt <= '0;
            nlp_seen <= '0;
        end else if (nlp_seen_pos || nlp_seen_neg || mii.rx_active) begin
            lf_cnt <= '0;
            if (nlp_seen != LINK_NLP_MIN) begin
                nlp_seen <= nlp_seen + {3'b000, nlp_seen_pos | nlp_seen_neg};
            end
            if (mii.rx_active || nlp_seen == LINK_NLP_MIN) begin
                link_valid <= 1'b1;
            end
        end else if (link_valid) begin
            lf_cnt <= lf_cnt + 1'b1;
            if (lf_cnt == CNT_W'(LINK_FAIL_CYCLES - 1)) begin
                link_valid <= 1'b0;
                nlp_seen <= '0;
                lf_cnt <= '0;
            end
        end
    end
    assign lf_evt = link_valid && !(nlp_seen_pos || nlp_seen_neg ||
        mii.rx_active) && lf_cnt == CNT_W'(LINK_FAIL_CYCLES - 1);
    // Polarity is judged only on idle link pulses or during negotiation
    assign pol_window = (!mode_100 && !mii.rx_active) ||
        (mode_100 && autoneg_active);
    // Polarity sense: a run of reversed pulses flips the receive data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pol_rev <= 1'b0;
            rev_cnt <= '0;
        end else if (ctrl[CTRL_POL_INH]) begin
            pol_rev <= 1'b0;
            rev_cnt <= '0;
        end else if (pol_window && nlp_seen_neg) begin
            if (rev_cnt != POL_REV_MIN) rev_cnt <= rev_cnt + 1'b1;
            if (rev_cnt == POL_REV_MIN - 1'b1) pol_rev <= 1'b1;
        end else if (pol_window && nlp_seen_pos) begin
            rev_cnt <= '0;
            pol_rev <= 1'b0;
        end
    end
    assign pol_evt = !ctrl[CTRL_POL_INH] && pol_window && nlp_seen_neg &&
        !nlp_seen_pos && rev_cnt == POL_REV_MIN - 1'b1;
    // Idle pulse timer keeps link pulses going when no data is sent
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nlp_cnt <= '0;
        end else if (nlp_cnt == CNT_W'(NLP_CYCLES - 1)) begin
            nlp_cnt <= '0;
        end else begin
            nlp_cnt <= nlp_cnt + 1'b1;
        end
    end
    // Line side: transmit gate and corrected receive stream
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line <= '0;
        end else begin
            line.tx_drive <= mii.tx_en && !cut;
            line.tx_data <= mii.tx_data && !cut;
            line.nlp_send <= (cut || !mii.tx_en) &&
                nlp_cnt == CNT_W'(NLP_CYCLES - 1);
            line.rx_data <= rx_data_raw ^ pol_rev;
        end
    end

    a_fd_col_low: assert property (@(posedge hclk) disable iff (!hresetn)
        full_duplex |=> !col) else $error("col high in full duplex");
    a_hd_col_set: assert property (@(posedge hclk) disable iff (!hresetn)
        !full_duplex && mii.tx_en && mii.rx_active |=> col)
        else $error("no collision on tx and rx");
    a_jab_cut_col: assert property (@(posedge hclk) disable iff (!hresetn)
        jab_evt |=> cut ##1 (col && !line.tx_drive) || full_duplex)
        else $error("jabber cut missing");
    a_cut_no_tx: assert property (@(posedge hclk) disable iff (!hresetn)
        cut |=> !line.tx_drive) else $error("tx leaks in cut");
    a_jab_latch: assert property (@(posedge hclk) disable iff (!hresetn)
        jab_evt |=> jab_lh) else $error("jabber flag not set");
    a_jab_inhibit: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl[CTRL_JAB_INH] && !cut |=> jab_st == JAB_IDLE)
        else $error("jabber ran while inhibited");
    a_sqe_start: assert property (@(posedge hclk) disable iff (!hresetn)
        sqe_st == SQE_IDLE && $fell(mii.tx_en) && sqe_ok
        |=> sqe_st == SQE_WAIT) else $error("heartbeat not started");
    a_sqe_block: assert property (@(posedge hclk) disable iff (!hresetn)
        !sqe_ok |=> sqe_st == SQE_IDLE)
        else $error("heartbeat while disallowed");
    a_sqe_len: assert property (@(posedge hclk) disable iff (!hresetn)
        sqe_st == SQE_ON && sqe_ok && sqe_on_cyc < 5'(SQE_ON_CYC - 1)
        |=> sqe_st == SQE_ON) else $error("heartbeat too short");
    a_pol_inh: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl[CTRL_POL_INH] |=> !pol_rev)
        else $error("polarity fixed while inhibited");
    a_pol_invert: assert property (@(posedge hclk) disable iff (!hresetn)
        pol_rev && $stable(pol_rev) |=> line.rx_data == !$past(rx_data_raw))
        else $error("rx data not inverted");
    a_link_fail: assert property (@(posedge hclk) disable iff (!hresetn)
        lf_evt |=> !link_valid ##1 irq_stat[IRQ_LFAIL])
        else $error("link fail not taken");
    a_latch_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        jab_lh && !stat_rd |=> jab_lh)
        else $error("jabber flag lost before read");
endmodule
`default_nettype wire

/* File: test/tbj_mac_model.sv */
// Far-side model: MAC transmit enable and data, receive carrier, and the
// remote link pulses. Assumes hclk from the bench; changes after rising edges.
`default_nettype none
module tbj_mac_model (
    input wire logic hclk,
    output tbj_pkg::tbj_mii_t mii,
    output logic nlp_pos = 1'b0,
    output logic nlp_neg = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    import tbj_pkg::*;
    logic tx_en_q = 1'b0;
    logic tx_bit_q = 1'b0;
    logic rx_q = 1'b0;
    logic pulses_on = 1'b0;
    logic pulse_rev = 1'b0;
    int gap = 0;
    assign mii = '{tx_en: tx_en_q, tx_data: tx_bit_q, rx_active: rx_q};
    // Data bit is redrawn at random every cycle of transmit enable so a stuck data path cannot hide
    always @(posedge hclk) begin
        tx_bit_q <= tx_en_q ? 1'($urandom) : 1'b0;
    end
    // One-cycle remote link pulse every 20 cycles, polarity selectable
    always @(posedge hclk) begin
        gap <= (gap == 19) ? 0 : gap + 1;
        nlp_pos <= pulses_on && !pulse_rev && gap == 19;
        nlp_neg <= pulses_on && pulse_rev && gap == 19;
    end
    task automatic set_tx(input logic v);
        @(posedge hclk);
        tx_en_q <= v;
    endtask
    task automatic set_rx(input logic v);
        @(posedge hclk);
        rx_q <= v;
    endtask
endmodule
`default_nettype wire

/* File: test/tenbase_t_collision_jabber_sqe_test.sv */
// Self-checking bench for the 10Base-T supervision block.
// Assumes short jabber, unjab, link-fail and pulse counts set below.
`default_nettype none
module tenbase_t_collision_jabber_sqe_test;
    timeunit 1ns;
    timeprecision 1ns;
    import tbj_pkg::*;
    localparam int JABC = 50;
    localparam int UNJABC = 40;
    localparam int LFC = 200;
    localparam int NLPC = 30;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, full_duplex, repeater_mode, mode_100;
    logic autoneg_active, rx_data_raw;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, col, irq, nlp_pos, nlp_neg;
    logic [31:0] hrdata;
    logic [31:0] q;
    logic tx_bit;
    tbj_mii_t mii;
    tbj_line_t line;
    logic [31:0] seen_q[$];
    logic [31:0] exp_q[$];
    int err_total = 0;
    int compares = 0;
    int n;

    tbj_supervisor #(.JAB_CYCLES(JABC), .UNJAB_CYCLES(UNJABC),
        .LINK_FAIL_CYCLES(LFC), .NLP_CYCLES(NLPC)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .mii(mii), .full_duplex(full_duplex),
        .repeater_mode(repeater_mode), .mode_100(mode_100),
        .autoneg_active(autoneg_active), .rx_data_raw(rx_data_raw),
        .nlp_seen_pos(nlp_pos), .nlp_seen_neg(nlp_neg), .col(col),
        .line(line), .irq(irq));
    tbj_mac_model i_mac (.hclk(hclk), .mii(mii), .nlp_pos(nlp_pos),
        .nlp_neg(nlp_neg));

    initial begin
        forever #25 hclk = ~hclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // Driver side records the pair; the watcher below does the comparing
    task automatic note(input logic [31:0] seen, input logic [31:0] exp);
        seen_q.push_back(seen);
        exp_q.push_back(exp);
    endtask
    always @(negedge hclk) begin
        while (seen_q.size() > 0) begin
            chk(seen_q.pop_front(), exp_q.pop_front());
        end
    end

    // Bounded wait on hready; a stuck bus counts as a mismatch
    task automatic wait_rdy();
        int wt;
        wt = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && wt < 50) begin
            @(posedge hclk);
            wt++;
        end
        if (wt >= 50) err_total++;
    endtask
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        hsize <= 3'b010;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        bus(1'b0, a, $urandom);
        note(q & m, e);
    endtask
    // Interrupt is looked at once the write has settled
    task automatic irq_at(input logic e);
        @(negedge hclk);
        note(32'(irq), 32'(e));
    endtask
    task automatic at_col(input int c, input logic e);
        repeat (c) @(posedge hclk);
        @(negedge hclk);
        note(32'(col), 32'(e));
    endtask
    // Received bit must come out one cycle later, inverted when reversed
    task automatic rx_chk(input logic inv);
        logic b;
        repeat (6) begin
            b = 1'($urandom);
            @(posedge hclk);
            rx_data_raw <= b;
            @(posedge hclk);
            @(negedge hclk);
            note(32'(line.rx_data), 32'(b ^ inv));
        end
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic close_out();
        repeat (2) @(negedge hclk);
        $display("compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (30000) @(posedge hclk);
        err_total++;
        close_out();
    end

    initial begin
        {hsel, hwrite, full_duplex, repeater_mode, mode_100} <= '0;
        {autoneg_active, rx_data_raw, htrans, haddr, hwdata} <= '0;
        hsize <= 3'b010;
        n = $urandom(33);
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values, control bits and an unmapped word
        rd(32'(OFS_CTRL), 32'hFFFF_FFFF, 32'h0000_0000);
        rd(32'(OFS_STAT), 32'hFFFF_FFFF, 32'h0000_0000);
        rd(32'(OFS_IRQ_MASK), 32'hFFFF_FFFF, 32'h0000_0000);
        wr(32'h0000_0010, 32'hFFFF_FFFF);
        rd(32'h0000_0010, 32'hFFFF_FFFF, 32'h0000_0000);
        note(32'(hresp), 32'h0000_0000);
        wr(32'(OFS_CTRL), 32'hFFFF_FFFF);
        rd(32'(OFS_CTRL), 32'hFFFF_FFFF, 32'h0000_002C);
        wr(32'(OFS_CTRL), 32'h0000_0000);
        i_mac.pulses_on <= 1'b1;
        repeat (200) @(posedge hclk);
        rd(32'(OFS_STAT), 32'h0000_0001, 32'h0000_0001);
        done("registers");
        // Overlap of transmit and receive, half then full duplex
        for (int i = 0; i < 2; i++) begin
            @(posedge hclk);
            repeater_mode <= 1'b1;
            full_duplex <= 1'(i);
            i_mac.set_tx(1'b1);
            i_mac.set_rx(1'b1);
            at_col(2, !i);
            repeat ($urandom_range(6, 2)) at_col(1, !i);
            i_mac.set_rx(1'b0);
            at_col(2, 1'b0);
            i_mac.set_tx(1'b0);
        end
        done("collision");
        // Heartbeat: enabled, repeater, full duplex, inhibited, link down
        for (int k = 0; k < 5; k++) begin
            @(posedge hclk);
            repeater_mode <= (k == 1);
            full_duplex <= (k == 2);
            wr(32'(OFS_CTRL), (k == 3) ? 32'h0000_0004 : 32'h0000_0000);
            if (k == 4) begin
                i_mac.pulses_on <= 1'b0;
                repeat (LFC + 20) @(posedge hclk);
                rd(32'(OFS_STAT), 32'h0000_0001, 32'h0000_0000);
                rd(32'(OFS_IRQ_STAT), 32'h0000_0004, 32'h0000_0004);
            end
            i_mac.set_tx(1'b1);
            repeat (10) @(posedge hclk);
            i_mac.set_tx(1'b0);
            at_col(12, 1'b0);
            at_col(8, k == 0);
            at_col(12, k == 0);
            at_col(14, 1'b0);
        end
        i_mac.pulses_on <= 1'b1;
        repeat (200) @(posedge hclk);
        rd(32'(OFS_STAT), 32'h0000_0001, 32'h0000_0001);
        done("heartbeat");
        // Jabber enabled then inhibited; interrupt masked and cleared
        repeater_mode <= 1'b1;
        wr(32'(OFS_IRQ_STAT), 32'h0000_0007);
        wr(32'(OFS_IRQ_MASK), 32'h0000_0001);
        for (int k = 0; k < 2; k++) begin
            wr(32'(OFS_CTRL), k ? 32'h0000_0020 : 32'h0000_0000);
            i_mac.set_tx(1'b1);
            repeat (JABC + 3) @(posedge hclk);
            @(negedge hclk);
            tx_bit = mii.tx_data;
            @(negedge hclk);
            note(32'(col), 32'(!k));
            note(32'(line.tx_drive), 32'(k));
            note(32'(line.tx_data), 32'(tx_bit && k));
            rd(32'(OFS_STAT), 32'h0000_0004, k ? 0 : 32'h0000_0004);
            i_mac.set_tx(1'b0);
            n = 0;
            repeat (NLPC + 2) begin
                @(negedge hclk);
                n += int'(line.nlp_send);
            end
            note(32'(n > 0), 32'h0000_0001);
            repeat (UNJABC) @(posedge hclk);
            rd(32'(OFS_STAT), 32'h0000_0004, k ? 0 : 32'h0000_0004);
            rd(32'(OFS_STAT), 32'h0000_0004, 32'h0000_0000);
            irq_at(!k);
            wr(32'(OFS_IRQ_MASK), 32'h0000_0000);
            irq_at(1'b0);
            wr(32'(OFS_IRQ_MASK), 32'h0000_0001);
            irq_at(!k);
            wr(32'(OFS_IRQ_STAT), 32'h0000_0001);
            irq_at(1'b0);
        end
        wr(32'(OFS_CTRL), 32'h0000_0000);
        done("jabber");
        // Polarity in 10 Mb/s idle, then during 100 Mb/s negotiation
        rx_chk(1'b0);
        for (int k = 0; k < 2; k++) begin
            @(posedge hclk);
            mode_100 <= 1'(k);
            autoneg_active <= 1'(k);
            i_mac.pulse_rev <= 1'b1;
            repeat (60) @(posedge hclk);
            rd(32'(OFS_STAT), 32'h0000_4000, 32'h0000_4000);
            rx_chk(1'b1);
            @(posedge hclk);
            i_mac.pulse_rev <= 1'b0;
            repeat (30) @(posedge hclk);
            rd(32'(OFS_STAT), 32'h0000_4000, 32'h0000_4000);
            rd(32'(OFS_STAT), 32'h0000_4000, 32'h0000_0000);
            rx_chk(1'b0);
        end
        // Inhibited correction must leave data and flag alone
        wr(32'(OFS_CTRL), 32'h0000_0008);
        i_mac.pulse_rev <= 1'b1;
        repeat (60) @(posedge hclk);
        rd(32'(OFS_STAT), 32'h0000_4000, 32'h0000_0000);
        rx_chk(1'b0);
        done("polarity");
        close_out();
    end
endmodule
`default_nettype wire
